// *** ccec_pkg.sv ***
// Operation
// [R1] early ack at remote read start when enabled
// [R2] software keeps early ack off for legacy serializers
// [R3] compare echoed data against sent data
// [R4] mismatch turns remote ack into local nack
// [R5] software keeps data check off for legacy serializers
// [R6] enhanced checking terminates transaction on channel error
// [R7] force code selects kind of injected error
// [R8] one error injected per nonzero code write
// [R9] frame select picks one of first eight frames
// [R10] control register per port, chosen by port select
// [R11] control register resets to 0x20
// [R12] sequence error clear-on-read or live copy
// [R13] controller error flag only with enhanced checking
package ccec_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] CTL_OFFSET = 8'h46;
  localparam logic [7:0] STATUS_OFFSET = 8'h47;
  localparam logic [7:0] PORT_SEL_OFFSET = 8'h4c;
  localparam logic [7:0] CTL_RESET = 8'h20;
  localparam logic [7:0] PORT_SEL_RESET = 8'h00;

  // ==========================================================
  // control register fields
  localparam int CTL_EARLY_ACK_BIT = 7;
  localparam int CTL_DATA_CHECK_BIT = 6;
  localparam int CTL_ENH_CHECK_BIT = 5;
  localparam int CTL_FORCE_LSB = 3;
  localparam int CTL_FORCE_W = 2;
  localparam int CTL_FRAME_LSB = 0;
  localparam int CTL_FRAME_W = 3;

  // ==========================================================
  // status register fields
  localparam int STS_SEQ_ERR_BIT = 5;
  localparam int STS_CTRLR_ERR_BIT = 4;

  // ==========================================================
  // force error codes and frame window
  localparam logic [1:0] FORCE_NONE = 2'h0;
  localparam logic [1:0] FORCE_CRC_SEL = 2'h1;
  localparam logic [1:0] FORCE_CRC_NEXT = 2'h2;
  localparam logic [1:0] FORCE_DATA_SEL = 2'h3;
  localparam logic [3:0] FRAME_WINDOW = 4'h8;

  typedef enum logic [1:0] {
    INJ_IDLE,
    INJ_WAIT_SEL,
    INJ_WAIT_NORMAL
  } inject_state_e;

endpackage

// *** ctrl_channel_error_ctl.sv ***
module ctrl_channel_error_ctl
  import ccec_pkg::*;
#(
  parameter int NPORTS = 4
)
(
  input wire logic clk,
  input wire logic arst_n,
  // local register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  output logic regRdValid,
  // per-port channel events
  input wire logic [NPORTS-1:0] remoteReadStart,
  input wire logic [NPORTS-1:0] respValid,
  input wire logic [NPORTS-1:0] respAck,
  input wire logic [NPORTS-1:0][7:0] echoData,
  input wire logic [NPORTS-1:0][7:0] sentData,
  input wire logic [NPORTS-1:0] awaitingResp,
  input wire logic [NPORTS-1:0] seqErrIn,
  input wire logic [NPORTS-1:0] crcErrIn,
  input wire logic [NPORTS-1:0] lockErrIn,
  input wire logic [NPORTS-1:0] portSeqErrSts,
  input wire logic [NPORTS-1:0] blockStart,
  input wire logic [NPORTS-1:0] ccFrame,
  input wire logic [NPORTS-1:0] normalFrame,
  // per-port results
  output logic [NPORTS-1:0] earlyAck,
  output logic [NPORTS-1:0] localAck,
  output logic [NPORTS-1:0] localNack,
  output logic [NPORTS-1:0] dataMismatch,
  output logic [NPORTS-1:0] terminateXfer,
  output logic [NPORTS-1:0] forceCrc,
  output logic [NPORTS-1:0] forceData,
  output logic [NPORTS-1:0] enhancedCheckEn
);

  localparam int PSW = (NPORTS > 1) ? $clog2(NPORTS) : 1;

  typedef struct packed {
    logic [NPORTS-1:0][7:0] ctl;
    logic [7:0] portSel;
    logic [NPORTS-1:0] seqErr;
    logic [NPORTS-1:0] ctrlrErr;
    logic [NPORTS-1:0] arm;
    logic [NPORTS-1:0] early;
    logic [NPORTS-1:0] ack;
    logic [NPORTS-1:0] nack;
    logic [NPORTS-1:0] mismatch;
    logic [NPORTS-1:0] term;
    logic [7:0] rdData;
    logic rdValid;
  } state_s;

  state_s stateReg;
  state_s stateNext;
  logic [PSW-1:0] selPort;
  logic selInRange;

  // ==========================================================
  // port selection
  // [R10] select copy
  assign selPort = stateReg.portSel[PSW-1:0];
  // a select past the last port reaches no copy and reads zero
  assign selInRange = ({24'h0, stateReg.portSel} < NPORTS);

  // ==========================================================
  // next state
  always_comb begin
    logic wrSel;
    logic rdStatus;
    logic chanErr;
    logic badEcho;
    logic [7:0] rd;
    wrSel = 1'b0;
    rdStatus = 1'b0;
    chanErr = 1'b0;
    badEcho = 1'b0;
    rd = 8'h00;
    stateNext = stateReg;
    stateNext.arm = '0;
    stateNext.rdValid = regRdEn;

    if (regWrEn && regAddr == PORT_SEL_OFFSET) begin
      stateNext.portSel = regWrData;
    end

    for (int p = 0; p < NPORTS; p++) begin
      wrSel = regWrEn && regAddr == CTL_OFFSET && selInRange && selPort == PSW'(p);
      rdStatus = regRdEn && regAddr == STATUS_OFFSET && selInRange && selPort == PSW'(p);
      chanErr = seqErrIn[p] || crcErrIn[p] || lockErrIn[p];

      // [R10] per-port write
      if (wrSel) begin
        stateNext.ctl[p] = regWrData;
        // [R8] arm on write
        stateNext.arm[p] = regWrData[CTL_FORCE_LSB +: CTL_FORCE_W] != FORCE_NONE;
      end

      // [R1] early ack
      stateNext.early[p] = stateReg.ctl[p][CTL_EARLY_ACK_BIT] && remoteReadStart[p];

      // [R3] echo compare
      badEcho = stateReg.ctl[p][CTL_DATA_CHECK_BIT] && echoData[p] != sentData[p];
      stateNext.mismatch[p] = respValid[p] && badEcho;
      // [R4] ack to nack
      stateNext.ack[p] = respValid[p] && respAck[p] && !badEcho;
      stateNext.nack[p] = respValid[p] && (!respAck[p] || badEcho);

      // [R6] terminate on error
      stateNext.term[p] = stateReg.ctl[p][CTL_ENH_CHECK_BIT] && awaitingResp[p] && chanErr;

      // [R12] clear on read, set wins
      if (rdStatus) begin
        stateNext.seqErr[p] = 1'b0;
        stateNext.ctrlrErr[p] = 1'b0;
      end
      if (stateReg.ctl[p][CTL_ENH_CHECK_BIT] && seqErrIn[p]) begin
        stateNext.seqErr[p] = 1'b1;
      end
      // [R13] controller error set
      if (stateReg.ctl[p][CTL_ENH_CHECK_BIT] && awaitingResp[p] && chanErr) begin
        stateNext.ctrlrErr[p] = 1'b1;
      end
    end

    // ========================================================
    // read mux
    if (regAddr == PORT_SEL_OFFSET) begin
      rd = stateReg.portSel;
    end else if (regAddr == CTL_OFFSET && selInRange) begin
      rd = stateReg.ctl[selPort];
    end else if (regAddr == STATUS_OFFSET && selInRange) begin
      // [R12] live copy when disabled
      if (stateReg.ctl[selPort][CTL_ENH_CHECK_BIT]) begin
        rd[STS_SEQ_ERR_BIT] = stateReg.seqErr[selPort];
      end else begin
        rd[STS_SEQ_ERR_BIT] = portSeqErrSts[selPort];
      end
      // [R13] gated report
      rd[STS_CTRLR_ERR_BIT] = stateReg.ctrlrErr[selPort]
        && stateReg.ctl[selPort][CTL_ENH_CHECK_BIT];
    end
    stateNext.rdData = regRdEn ? rd : stateReg.rdData;
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      // [R11] control reset value
      stateReg.ctl <= {NPORTS{CTL_RESET}};
      stateReg.portSel <= PORT_SEL_RESET;
      stateReg.seqErr <= '0;
      stateReg.ctrlrErr <= '0;
      stateReg.arm <= '0;
      stateReg.early <= '0;
      stateReg.ack <= '0;
      stateReg.nack <= '0;
      stateReg.mismatch <= '0;
      stateReg.term <= '0;
      stateReg.rdData <= 8'h00;
      stateReg.rdValid <= 1'b0;
    end else begin
      stateReg <= stateNext;
    end
  end

  // ==========================================================
  // per-port error injection
  for (genvar p = 0; p < NPORTS; p++) begin : gInject
    frame_error_injector injector (
      .clk(clk),
      .arst_n(arst_n),
      .arm(stateReg.arm[p]),
      .forceMode(stateReg.ctl[p][CTL_FORCE_LSB +: CTL_FORCE_W]),
      .frameSelect(stateReg.ctl[p][CTL_FRAME_LSB +: CTL_FRAME_W]),
      .blockStart(blockStart[p]),
      .ccFrame(ccFrame[p]),
      .normalFrame(normalFrame[p]),
      .forceCrc(forceCrc[p]),
      .forceData(forceData[p])
    );
    assign enhancedCheckEn[p] = stateReg.ctl[p][CTL_ENH_CHECK_BIT];
  end

  assign regRdData = stateReg.rdData;
  assign regRdValid = stateReg.rdValid;
  assign earlyAck = stateReg.early;
  assign localAck = stateReg.ack;
  assign localNack = stateReg.nack;
  assign dataMismatch = stateReg.mismatch;
  assign terminateXfer = stateReg.term;

endmodule // ctrl_channel_error_ctl

// *** ctrl_channel_error_ctl_monitor.sv ***
module ctrl_channel_error_ctl_monitor
  import ccec_pkg::*;
#(
  parameter int NPORTS = 4
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic regRdEn,
  input wire logic regRdValid,
  input wire logic [NPORTS-1:0] remoteReadStart,
  input wire logic [NPORTS-1:0] respValid,
  input wire logic [NPORTS-1:0][7:0] echoData,
  input wire logic [NPORTS-1:0][7:0] sentData,
  input wire logic [NPORTS-1:0] awaitingResp,
  input wire logic [NPORTS-1:0] crcErrIn,
  input wire logic [NPORTS-1:0] ccFrame,
  input wire logic [NPORTS-1:0] normalFrame,
  input wire logic [NPORTS-1:0] earlyAck,
  input wire logic [NPORTS-1:0] localAck,
  input wire logic [NPORTS-1:0] localNack,
  input wire logic [NPORTS-1:0] dataMismatch,
  input wire logic [NPORTS-1:0] terminateXfer,
  input wire logic [NPORTS-1:0] forceCrc,
  input wire logic [NPORTS-1:0] forceData,
  input wire logic [NPORTS-1:0] enhancedCheckEn
);
  // ==========================================================
  // checks
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence readAnswered;
    regRdEn ##1 regRdValid;
  endsequence
  AST_READ_ANSWER: assert property (regRdEn |-> readAnswered)
    else $error("read not answered");
  AST_EARLY_ACK_CAUSE: assert property ((earlyAck & ~$past(remoteReadStart)) == 0)
    else $error("early ack without read start");
  AST_ONE_ANSWER: assert property (respValid[0] |=> localAck[0] ^ localNack[0])
    else $error("response not answered once");
  AST_ANSWER_CAUSE: assert property (localAck[0] | localNack[0] |-> $past(respValid[0]))
    else $error("answer without response");
  AST_MISMATCH: assert property (dataMismatch[0] |->
    localNack[0] && $past(echoData[0]) != $past(sentData[0]))
    else $error("mismatch flag wrong");
  AST_TERMINATE: assert property (crcErrIn[0] && awaitingResp[0] && enhancedCheckEn[0]
    |=> terminateXfer[0])
    else $error("error did not terminate");
  AST_FORCE_DATA: assert property (forceData[0] |-> $past(ccFrame[0]))
    else $error("data error off frame");
  AST_FORCE_CRC: assert property (forceCrc[0] |-> $past(ccFrame[0]) || $past(normalFrame[0]))
    else $error("crc error off frame");
  AST_SINGLE_SHOT: assert property (forceCrc[0] |=> !forceCrc[0])
    else $error("crc error repeated");
endmodule // ctrl_channel_error_ctl_monitor

bind ctrl_channel_error_ctl ctrl_channel_error_ctl_monitor #(.NPORTS(NPORTS)) i_mon (.*);

// *** ctrl_channel_error_ctl_tb.sv ***
module ctrl_channel_error_ctl_tb
  import ccec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0;
  logic arst_n = 0;
  logic [7:0] regAddr = 0, regWrData = 0, regRdData;
  logic regWrEn = 0, regRdEn = 0, regRdValid, req = 0, corrupt = 0, mValid, mAck;
  logic [3:0] remoteReadStart = 0, awaitingResp = 0, seqErrIn = 0, crcErrIn = 0, lockErrIn = 0;
  logic [3:0] portSeqErrSts = 0, blockStart = 0, ccFrame = 0, normalFrame = 0, lat = 1;
  logic [3:0][7:0] sentData = '0;
  logic [7:0] mEcho;
  logic [3:0] earlyAck, localAck, localNack, dataMismatch, terminateXfer, forceCrc, forceData;
  logic [3:0] enhancedCheckEn;
  int failures = 0, checked = 0, crcCnt = 0, dataCnt = 0, c0, d0;
  // ==========================================================
  // structure
  always #10 clk = ~clk;
  always @(posedge clk) begin
    crcCnt <= crcCnt + forceCrc[0];
    dataCnt <= dataCnt + forceData[0];
  end
  serializer_model i_ser (.clk(clk), .arst_n(arst_n), .req(req), .sentByte(sentData[0]),
    .corrupt(corrupt), .lat(lat), .respValid(mValid), .respAck(mAck), .echoData(mEcho));
  ctrl_channel_error_ctl i_dut (.clk(clk), .arst_n(arst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .regRdValid(regRdValid), .remoteReadStart(remoteReadStart), .respValid({3'h0, mValid}),
    .respAck({3'h0, mAck}), .echoData({24'h0, mEcho}), .sentData(sentData),
    .awaitingResp(awaitingResp), .seqErrIn(seqErrIn), .crcErrIn(crcErrIn),
    .lockErrIn(lockErrIn), .portSeqErrSts(portSeqErrSts), .blockStart(blockStart),
    .ccFrame(ccFrame), .normalFrame(normalFrame), .earlyAck(earlyAck), .localAck(localAck),
    .localNack(localNack), .dataMismatch(dataMismatch), .terminateXfer(terminateXfer),
    .forceCrc(forceCrc), .forceData(forceData), .enhancedCheckEn(enhancedCheckEn));
  // ==========================================================
  // tasks
  task step; @(posedge clk); #1; endtask
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", n, e, g);
      failures++;
    end
  endtask
  task final_report;
    if (failures == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    regAddr = a; regWrData = d; regWrEn = 1; step; regWrEn = 0; step;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e, input string n);
    regAddr = a; regRdEn = 1; step; regRdEn = 0;
    chk("regRdValid", 8'h01, {7'h0, regRdValid}); chk(n, e, regRdData); step;
  endtask
  task automatic pulse(ref logic [3:0] s, input logic [3:0] v);
    step; s = v; step; s = 0;
  endtask
  task xfer(input logic [7:0] b, input logic bad, input logic [3:0] l);
    int i;
    sentData[0] = b; corrupt = bad; lat = l;
    step; req = 1; step; req = 0;
    for (i = 0; i < 12 && (localAck[0] | localNack[0]) !== 1'b1; i++) step;
    chk("localAck", {7'h0, !bad}, {7'h0, localAck[0]});
    chk("localNack", {7'h0, bad}, {7'h0, localNack[0]});
    chk("dataMismatch", {7'h0, bad}, {7'h0, dataMismatch[0]});
  endtask
  task frames;
    for (int i = 0; i < 9; i++) begin
      ccFrame[0] = 1; blockStart[0] = (i == 0); step;
      ccFrame[0] = 0; blockStart[0] = 0; normalFrame[0] = 1; step; normalFrame[0] = 0;
    end
    step; step;
  endtask
  // ==========================================================
  // tests
  initial begin
    repeat (12) @(posedge clk);
    #1 arst_n = 1;
    rd(CTL_OFFSET, CTL_RESET, "ctl");
    rd(PORT_SEL_OFFSET, 8'h00, "portSel");
    wr(PORT_SEL_OFFSET, 8'h01); wr(CTL_OFFSET, 8'ha0);
    rd(CTL_OFFSET, 8'ha0, "ctlPort1");
    rd(8'h50, 8'h00, "unmapped");
    wr(PORT_SEL_OFFSET, 8'h04);
    rd(CTL_OFFSET, 8'h00, "ctlNoPort");
    wr(PORT_SEL_OFFSET, 8'h00);
    rd(CTL_OFFSET, CTL_RESET, "ctlPort0");
    pulse(remoteReadStart, 4'h3); chk("earlyAck", 8'h02, {4'h0, earlyAck});
    wr(CTL_OFFSET, 8'he0);
    pulse(remoteReadStart, 4'h1); chk("earlyAck", 8'h01, {4'h0, earlyAck});
    xfer(8'h5a, 0, 1);
    xfer(8'ha5, 1, 5);
    awaitingResp = 4'h1;
    pulse(crcErrIn, 4'h1); chk("terminate", 8'h01, {7'h0, terminateXfer[0]});
    pulse(lockErrIn, 4'h1); chk("terminate", 8'h01, {7'h0, terminateXfer[0]});
    rd(STATUS_OFFSET, 8'h10, "status");
    rd(STATUS_OFFSET, 8'h00, "status");
    pulse(seqErrIn, 4'h1); rd(STATUS_OFFSET, 8'h30, "status");
    wr(CTL_OFFSET, 8'h00);
    chk("enhancedCheckEn", 8'h00, {7'h0, enhancedCheckEn[0]});
    pulse(crcErrIn, 4'h1); chk("terminate", 8'h00, {7'h0, terminateXfer[0]});
    portSeqErrSts = 4'h1; step; rd(STATUS_OFFSET, 8'h20, "status");
    awaitingResp = 0;
    for (int m = 1; m < 4; m++) begin
      c0 = crcCnt; d0 = dataCnt;
      wr(CTL_OFFSET, {3'b001, m[1:0], m[1:0] * 2'h2 + 3'h1});
      frames; frames;
      chk("crcShots", (m == 3) ? 8'h00 : 8'h01, 8'(crcCnt - c0));
      chk("dataShots", (m == 3) ? 8'h01 : 8'h00, 8'(dataCnt - d0));
    end
    final_report;
  end
  initial begin
    #50000;
    failures++;
    final_report;
  end
endmodule // ctrl_channel_error_ctl_tb

// *** frame_error_injector.sv ***
module frame_error_injector
  import ccec_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic arm,
  input wire logic [1:0] forceMode,
  input wire logic [2:0] frameSelect,
  input wire logic blockStart,
  input wire logic ccFrame,
  input wire logic normalFrame,
  output logic forceCrc,
  output logic forceData
);

  typedef struct packed {
    inject_state_e state;
    logic [3:0] frameIdx;
    logic [1:0] mode;
    logic [2:0] sel;
    logic crc;
    logic data;
  } state_s;

  state_s stateReg;
  state_s stateNext;
  logic [3:0] curIdx;

  // ==========================================================
  // sequencer
  always_comb begin
    stateNext = stateReg;
    stateNext.crc = 1'b0;
    stateNext.data = 1'b0;
    // a block start restarts numbering at the frame sent with it
    curIdx = blockStart ? 4'h0 : stateReg.frameIdx;
    if (ccFrame && curIdx < FRAME_WINDOW) begin
      stateNext.frameIdx = curIdx + 4'h1;
    end else begin
      stateNext.frameIdx = curIdx;
    end
    unique case (stateReg.state)
      INJ_IDLE: begin
      end
      // [R9] frame index match
      INJ_WAIT_SEL: begin
        if (ccFrame && curIdx == {1'b0, stateReg.sel}) begin
          // [R7] mode decode
          unique case (stateReg.mode)
            FORCE_CRC_SEL: begin
              stateNext.crc = 1'b1;
              stateNext.state = INJ_IDLE;
            end
            FORCE_DATA_SEL: begin
              stateNext.data = 1'b1;
              stateNext.state = INJ_IDLE;
            end
            FORCE_CRC_NEXT: begin
              stateNext.state = INJ_WAIT_NORMAL;
            end
            FORCE_NONE: begin
              stateNext.state = INJ_IDLE;
            end
          endcase
        end
      end
      INJ_WAIT_NORMAL: begin
        if (normalFrame) begin
          stateNext.crc = 1'b1;
          stateNext.state = INJ_IDLE;
        end
      end
      // the fourth state code is unused; fall back to idle
      default: begin
        stateNext.state = INJ_IDLE;
      end
    endcase
    // [R8] single shot per arm
    if (arm) begin
      stateNext.mode = forceMode;
      stateNext.sel = frameSelect;
      stateNext.state = (forceMode == FORCE_NONE) ? INJ_IDLE : INJ_WAIT_SEL;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stateReg <= '{state: INJ_IDLE, frameIdx: 4'h0, mode: 2'h0, sel: 3'h0,
                    crc: 1'b0, data: 1'b0};
    end else begin
      stateReg <= stateNext;
    end
  end

  assign forceCrc = stateReg.crc;
  assign forceData = stateReg.data;

endmodule // frame_error_injector

// *** serializer_model.sv ***
module serializer_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic req,
  input wire logic [7:0] sentByte,
  input wire logic corrupt,
  input wire logic [3:0] lat,
  output logic respValid,
  output logic respAck,
  output logic [7:0] echoData
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  logic [7:0] held;
  // ==========================================================
  // echo after lat cycles; idle echo toggles, never stale
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 0;
      respValid <= 0;
      respAck <= 0;
      echoData <= 8'h00;
      held <= 8'h00;
    end else begin
      respValid <= 0;
      echoData <= ~echoData;
      if (req) begin
        cnt <= lat;
        held <= corrupt ? sentByte ^ 8'h01 : sentByte;
      end else if (cnt == 1) begin
        respValid <= 1;
        respAck <= 1;
        echoData <= held;
        cnt <= 0;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule // serializer_model
